// ---- rtl/hu_dev_end.sv ----
/*
 * Device end: FIFO, UART core with baud generator and flow control, and
 * the device top holding the HCI UART, wake lines and peripheral UART.
 * Assumes firmware decodes the vendor commands and drives baudLoad and
 * wakeEnable; inputs are synchronous to mclk.
 */
`timescale 1ns/1ps
`include "hu_map.svh"

// ----------------------------------------------------------------------
// Byte FIFO in flip-flops
// ----------------------------------------------------------------------
module hu_fifo #(
    parameter int DEPTH = `HU_HCI_DEPTH
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] wrData,
    input wire logic wrValid,
    output logic wrReady,
    output logic [7:0] rdData,
    output logic rdValid,
    input wire logic rdReady,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [7:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    wire doWr = wrValid & wrReady;
    wire doRd = rdReady & rdValid;
    wire [CW-1:0] next_level = level + CW'(doWr) - CW'(doRd);
    wire [AW-1:0] wrPtrInc = (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + AW'(1);
    wire [AW-1:0] rdPtrInc = (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + AW'(1);

    assign rdData = mem[rdPtr];

    // Pointers and flags; flags come from the next level so they are exact
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            level <= '0;
            wrReady <= 1'b0;
            rdValid <= 1'b0;
        end else begin
            if (doWr) wrPtr <= wrPtrInc;
            if (doRd) rdPtr <= rdPtrInc;
            level <= next_level;
            wrReady <= next_level != CW'(DEPTH);
            rdValid <= next_level != '0;
        end
    end

    // Storage carries no reset: contents are only read below the level
    always_ff @(posedge mclk) begin
        if (doWr) mem[wrPtr] <= wrData;
    end
endmodule

// ----------------------------------------------------------------------
// UART core: baud generator, transmitter, receiver, two FIFOs
// ----------------------------------------------------------------------
module hu_uart_core #(
    parameter int DEPTH = `HU_HCI_DEPTH
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire hu_pkg::hu_baud_t baudValue,
    input wire logic baudLoad,
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady,
    output logic [7:0] rxData,
    output logic rxValid,
    input wire logic rxReady,
    output logic txPending,
    input wire logic rxd,
    output logic txd,
    output logic rtsN,
    input wire logic ctsN
);
    localparam int CW = $clog2(DEPTH + 1);
    hu_pkg::hu_baud_t curBaud;
    hu_pkg::hu_baud_t pendBaud;
    logic pendLoad;
    logic [24:0] acc;
    hu_pkg::hu_bit_state_t txState;
    hu_pkg::hu_bit_state_t rxState;
    logic [1:0] txSub;
    logic [1:0] rxSub;
    logic [2:0] txBit;
    logic [2:0] rxBit;
    logic [7:0] txShift;
    logic [7:0] rxShift;
    logic [7:0] txFifoData;
    logic txFifoValid;
    logic [CW-1:0] rxLevel;
    logic [CW-1:0] txLevel;
    logic rxFifoReady;

    // Baud generator: rational accumulator, average rate exact for any integer baud
    wire [24:0] accSum = acc + 25'(curBaud) * `HU_OSR;
    wire tick = accSum >= `HU_FCLK;
    wire [24:0] next_acc = tick ? accSum - `HU_FCLK : accSum;
    wire bothIdle = (txState == hu_pkg::ST_IDLE) & (rxState == hu_pkg::ST_IDLE);
    // Out-of-range requests are clamped to the supported span
    wire hu_pkg::hu_baud_t clampBaud = (baudValue < `HU_BAUD_MIN) ? `HU_BAUD_MIN :
        (baudValue > `HU_BAUD_MAX) ? `HU_BAUD_MAX : baudValue;

    // Rate switch waits for both engines to idle so no character is torn
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            curBaud <= `HU_BAUD_DEFAULT;
            pendBaud <= `HU_BAUD_DEFAULT;
            pendLoad <= 1'b0;
            acc <= '0;
        end else begin
            acc <= next_acc;
            if (baudLoad) begin
                pendBaud <= clampBaud;
                pendLoad <= 1'b1;
            end else if (pendLoad && bothIdle) begin
                curBaud <= pendBaud;
                pendLoad <= 1'b0;
            end
        end
    end

    // Transmit side: new character only starts while the peer allows it
    wire txStart = tick & (txState == hu_pkg::ST_IDLE) & txFifoValid & ~ctsN;
    wire txEdge = tick & (txSub == `HU_TICK_LAST);

    hu_fifo #(.DEPTH(DEPTH)) txFifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .wrData(txData),
        .wrValid(txValid),
        .wrReady(txReady),
        .rdData(txFifoData),
        .rdValid(txFifoValid),
        .rdReady(txStart),
        .level(txLevel)
    );

    // Transmitter: 1 start, 8 data LSB first, 1 stop, 4 ticks per bit
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            txState <= hu_pkg::ST_IDLE;
            txSub <= '0;
            txBit <= '0;
            txShift <= '0;
            txd <= 1'b1;
        end else if (tick) begin
            txSub <= txSub + 2'(1);
            case (txState)
                hu_pkg::ST_IDLE: begin
                    if (txStart) begin
                        txShift <= txFifoData;
                        txd <= 1'b0;
                        txSub <= '0;
                        txState <= hu_pkg::ST_START;
                    end
                end
                hu_pkg::ST_START: begin
                    if (txEdge) begin
                        txd <= txShift[0];
                        txBit <= `HU_BIT_FIRST;
                        txState <= hu_pkg::ST_DATA;
                    end
                end
                hu_pkg::ST_DATA: begin
                    if (txEdge) begin
                        txShift <= txShift >> 1;
                        txBit <= txBit + 3'(1);
                        txd <= (txBit == `HU_BIT_LAST) ? 1'b1 : txShift[1];
                        if (txBit == `HU_BIT_LAST) txState <= hu_pkg::ST_STOP;
                    end
                end
                hu_pkg::ST_STOP: begin
                    if (txEdge) txState <= hu_pkg::ST_IDLE;
                end
                default: txState <= hu_pkg::ST_IDLE;
            endcase
        end
    end

    // Receiver samples mid-bit, two ticks after the start edge is seen,
    // leaving about half a bit of margin for the combined rate error
    wire rxMid = tick & (rxSub == `HU_TICK_SAMPLE);
    wire rxPush = rxMid & (rxState == hu_pkg::ST_STOP) & rxd & rxFifoReady;

    // Receiver state machine
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rxState <= hu_pkg::ST_IDLE;
            rxSub <= '0;
            rxBit <= '0;
            rxShift <= '0;
        end else if (tick) begin
            rxSub <= rxSub + 2'(1);
            case (rxState)
                hu_pkg::ST_IDLE: begin
                    if (!rxd) begin
                        rxSub <= `HU_TICK_FIRST;
                        rxState <= hu_pkg::ST_START;
                    end
                end
                hu_pkg::ST_START: begin
                    if (rxMid) begin
                        rxBit <= `HU_BIT_FIRST;
                        // A glitch shorter than half a bit is not a start
                        rxState <= rxd ? hu_pkg::ST_IDLE : hu_pkg::ST_DATA;
                    end
                end
                hu_pkg::ST_DATA: begin
                    if (rxMid) begin
                        rxShift <= {rxd, rxShift[7:1]};
                        rxBit <= rxBit + 3'(1);
                        if (rxBit == `HU_BIT_LAST) rxState <= hu_pkg::ST_STOP;
                    end
                end
                hu_pkg::ST_STOP: begin
                    if (rxMid) rxState <= hu_pkg::ST_IDLE; // Bad stop drops the byte
                end
                default: rxState <= hu_pkg::ST_IDLE;
            endcase
        end
    end

    hu_fifo #(.DEPTH(DEPTH)) rxFifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .wrData(rxShift),
        .wrValid(rxPush),
        .wrReady(rxFifoReady),
        .rdData(rxData),
        .rdValid(rxValid),
        .rdReady(rxReady),
        .level(rxLevel)
    );

    // RTS drops with room left for bytes the peer already has in flight
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rtsN <= 1'b0;
            txPending <= 1'b0;
        end else begin
            rtsN <= rxLevel >= CW'(DEPTH - `HU_RTS_MARGIN);
            txPending <= txFifoValid | (txState != hu_pkg::ST_IDLE);
        end
    end
endmodule

// ----------------------------------------------------------------------
// Device top: HCI UART, wake lines, peripheral UART with pin routing
// ----------------------------------------------------------------------
module hu_dev_end (
    input wire logic mclk,
    input wire logic rst_n,
    hu_link_if.dev link,
    input wire hu_pkg::hu_baud_t hciBaudValue,
    input wire logic hciBaudLoad,
    input wire logic [7:0] hciTxData,
    input wire logic hciTxValid,
    output logic hciTxReady,
    output logic [7:0] hciRxData,
    output logic hciRxValid,
    input wire logic hciRxReady,
    input wire logic wakeEnable,
    input wire logic hostWakeReq,
    output logic deviceAwakeReq,
    input wire hu_pkg::hu_baud_t periBaudValue,
    input wire logic periBaudLoad,
    input wire logic [7:0] periTxData,
    input wire logic periTxValid,
    output logic periTxReady,
    output logic [7:0] periRxData,
    output logic periRxValid,
    input wire logic periRxReady,
    input wire hu_pkg::hu_pin_sel_t periTxdPin,
    input wire hu_pkg::hu_pin_sel_t periRtsPin,
    input wire hu_pkg::hu_pin_sel_t periRxdPin,
    input wire hu_pkg::hu_pin_sel_t periCtsPin,
    input wire logic [`HU_GPIO_COUNT-1:0] gpioIn,
    output logic [`HU_GPIO_COUNT-1:0] gpioOut,
    output logic [`HU_GPIO_COUNT-1:0] gpioOe
);
    logic hciPending;
    logic periTxd;
    logic periRtsN;

    hu_uart_core #(.DEPTH(`HU_HCI_DEPTH)) hciCore (
        .mclk(mclk),
        .rst_n(rst_n),
        .baudValue(hciBaudValue),
        .baudLoad(hciBaudLoad),
        .txData(hciTxData),
        .txValid(hciTxValid),
        .txReady(hciTxReady),
        .rxData(hciRxData),
        .rxValid(hciRxValid),
        .rxReady(hciRxReady),
        .txPending(hciPending),
        .rxd(link.hostTxd),
        .txd(link.devTxd),
        .rtsN(link.devRtsN),
        .ctsN(link.hostRtsN)
    );

    // Wake lines stay low until firmware enables them
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            link.deviceToHostWake <= 1'b0;
            deviceAwakeReq <= 1'b0;
        end else begin
            link.deviceToHostWake <= wakeEnable & (hciPending | hostWakeReq);
            deviceAwakeReq <= wakeEnable & link.hostToDeviceWake;
        end
    end

    // Peripheral inputs come from the selected pin; unrouted RXD idles high, unrouted CTS reads low (send allowed)
    wire periRxd = (periRxdPin < 6'(`HU_GPIO_COUNT)) ? gpioIn[periRxdPin] : 1'b1;
    wire periCtsN = (periCtsPin < 6'(`HU_GPIO_COUNT)) ? gpioIn[periCtsPin] : 1'b0;

    hu_uart_core #(.DEPTH(`HU_PERI_DEPTH)) periCore (
        .mclk(mclk),
        .rst_n(rst_n),
        .baudValue(periBaudValue),
        .baudLoad(periBaudLoad),
        .txData(periTxData),
        .txValid(periTxValid),
        .txReady(periTxReady),
        .rxData(periRxData),
        .rxValid(periRxValid),
        .rxReady(periRxReady),
        .txPending(),
        .rxd(periRxd),
        .txd(periTxd),
        .rtsN(periRtsN),
        .ctsN(periCtsN)
    );

    // Output routing per pin; TX wins if both outputs select one pin
    for (genvar i = 0; i < `HU_GPIO_COUNT; i++) begin : gPin
        wire selTx = periTxdPin == 6'(i);
        wire selRts = periRtsPin == 6'(i);
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                gpioOut[i] <= 1'b1;
                gpioOe[i] <= 1'b0;
            end else begin
                gpioOut[i] <= selTx ? periTxd : periRtsN;
                gpioOe[i] <= selTx | selRts;
            end
        end
    end
endmodule

// ---- rtl/hu_host_end.sv ----
/*
 * Host end of the HCI UART link: the same UART core facing the device,
 * plus the host-to-device wake line. Assumes hu_dev_end.sv is compiled
 * first for hu_uart_core.
 */
`timescale 1ns/1ps
`include "hu_map.svh"

module hu_host_end (
    input wire logic mclk,
    input wire logic rst_n,
    hu_link_if.host link,
    input wire hu_pkg::hu_baud_t baudValue,
    input wire logic baudLoad,
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady,
    output logic [7:0] rxData,
    output logic rxValid,
    input wire logic rxReady,
    input wire logic wakeDevice,
    output logic hostWoken
);
    // ------------------------------------------------------------------
    // Serial side, started at the default rate like the device
    // ------------------------------------------------------------------
    hu_uart_core #(.DEPTH(`HU_HOST_DEPTH)) hostCore (
        .mclk(mclk),
        .rst_n(rst_n),
        .baudValue(baudValue),
        .baudLoad(baudLoad),
        .txData(txData),
        .txValid(txValid),
        .txReady(txReady),
        .rxData(rxData),
        .rxValid(rxValid),
        .rxReady(rxReady),
        .txPending(),
        .rxd(link.devTxd),
        .txd(link.hostTxd),
        .rtsN(link.hostRtsN),
        .ctsN(link.devRtsN)
    );

    // ------------------------------------------------------------------
    // Wake lines: drive ours, report the device's
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            link.hostToDeviceWake <= 1'b0;
            hostWoken <= 1'b0;
        end else begin
            link.hostToDeviceWake <= wakeDevice;
            hostWoken <= link.deviceToHostWake;
        end
    end
endmodule

// ---- rtl/hu_link_if.sv ----
/*
 * The four-wire serial link plus the two wake lines between the device
 * and the host. Assumes both ends run on the same mclk.
 */
`timescale 1ns/1ps

interface hu_link_if;
    logic devTxd;
    logic hostTxd;
    logic devRtsN;
    logic hostRtsN;
    logic hostToDeviceWake;
    logic deviceToHostWake;

    // ------------------------------------------------------------------
    // One view per party
    // ------------------------------------------------------------------
    modport dev (
        output devTxd,
        output devRtsN,
        output deviceToHostWake,
        input hostTxd,
        input hostRtsN,
        input hostToDeviceWake
    );
    modport host (
        output hostTxd,
        output hostRtsN,
        output hostToDeviceWake,
        input devTxd,
        input devRtsN,
        input deviceToHostWake
    );
endinterface

// ---- rtl/hu_map.svh ----
/*
 * Constants of the HCI UART pair: clock, baud, FIFO depths, pin count.
 * Assumes the 10 MHz mclk.
 */
`ifndef HU_MAP_SVH
`define HU_MAP_SVH

// ----------------------------------------------------------------------
// Clock and baud rates (bit/s)
// ----------------------------------------------------------------------
`define HU_FCLK 25'h98_9680
`define HU_BAUD_MIN 21'h1_C200
`define HU_BAUD_MAX 21'h16_E360
`define HU_BAUD_DEFAULT 21'h1_C200
`define HU_OSR 25'h4

// ----------------------------------------------------------------------
// Oversampling ticks within one bit, and bits within one character
// ----------------------------------------------------------------------
`define HU_TICK_FIRST 2'h1
`define HU_TICK_SAMPLE 2'h2
`define HU_TICK_LAST 2'h3
`define HU_BIT_FIRST 3'h0
`define HU_BIT_LAST 3'h7

// ----------------------------------------------------------------------
// FIFO depths, flow control margin and pin count
// ----------------------------------------------------------------------
`define HU_HCI_DEPTH 32'h0000_0410
`define HU_PERI_DEPTH 32'h0000_0100
`define HU_HOST_DEPTH 32'h0000_0100
`define HU_RTS_MARGIN 32'h0000_0010
`define HU_GPIO_COUNT 32'h0000_0028

`endif

// ---- rtl/hu_pkg.sv ----
/*
 * Types shared by both ends of the HCI UART link.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package hu_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} hu_bit_state_t;
    typedef logic [20:0] hu_baud_t;
    typedef logic [5:0] hu_pin_sel_t;

endpackage

// ---- verif/hci_uart_with_wake_lines_tb.sv ----
/*
 * Bench: both ends on the link interface, peripheral UART looped on one pin.
 * Assumes design files and the checker compile first.
 */
`timescale 1ns/1ps
`include "hu_map.svh"

module hci_uart_with_wake_lines_tb;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    hu_pkg::hu_baud_t baudValue = `HU_BAUD_DEFAULT;
    logic baudLoad = 1'b0, wakeEnable = 1'b0, hostWakeReq = 1'b0, wakeDevice = 1'b0;
    logic [7:0] hciTxData = 8'h00, periTxData = 8'h00, hTxData = 8'h00;
    logic hciTxValid = 1'b0, periTxValid = 1'b0, hTxValid = 1'b0, holdHost = 1'b0;
    logic hciRxReady = 1'b0, periRxReady = 1'b0, hRxReady = 1'b0;
    logic hciTxReady, periTxReady, hTxReady, hciRxValid, periRxValid, hRxValid;
    logic deviceAwakeReq, hostWoken;
    logic [7:0] hciRxData, periRxData, hRxData;
    hu_pkg::hu_pin_sel_t pinTx = 6'h27, pinRx = 6'h27, pinRts = 6'h07, pinCts = 6'h3F;
    logic [`HU_GPIO_COUNT-1:0] gpioIn, gpioOut, gpioOe;
    logic [7:0] devQ[$], hostQ[$], periQ[$], expHost[$], expDev[$], expPeri[$];
    int seed = 5949;
    int failures = 0;
    int total_checks = 0;

    always #50 mclk = ~mclk;

    // Loopback with pull-up
    assign gpioIn = (gpioOut & gpioOe) | ~gpioOe;

    // ------------------------------------------------------------------
    // Design, interface and checker
    // ------------------------------------------------------------------
    hu_link_if link();

    hu_dev_end u_hu_dev_end (
        .mclk(mclk), .rst_n(rst_n), .link(link),
        .hciBaudValue(baudValue), .hciBaudLoad(baudLoad), .hciTxData(hciTxData),
        .hciTxValid(hciTxValid), .hciTxReady(hciTxReady), .hciRxData(hciRxData),
        .hciRxValid(hciRxValid), .hciRxReady(hciRxReady), .wakeEnable(wakeEnable),
        .hostWakeReq(hostWakeReq), .deviceAwakeReq(deviceAwakeReq),
        .periBaudValue(baudValue), .periBaudLoad(baudLoad), .periTxData(periTxData),
        .periTxValid(periTxValid), .periTxReady(periTxReady), .periRxData(periRxData),
        .periRxValid(periRxValid), .periRxReady(periRxReady), .periTxdPin(pinTx),
        .periRtsPin(pinRts), .periRxdPin(pinRx), .periCtsPin(pinCts),
        .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe)
    );

    hu_host_end u_hu_host_end (
        .mclk(mclk), .rst_n(rst_n), .link(link), .baudValue(baudValue), .baudLoad(baudLoad),
        .txData(hTxData), .txValid(hTxValid), .txReady(hTxReady), .rxData(hRxData),
        .rxValid(hRxValid), .rxReady(hRxReady), .wakeDevice(wakeDevice), .hostWoken(hostWoken)
    );

    hu_link_sva u_hu_link_sva (
        .mclk(mclk), .rst_n(rst_n), .devTxd(link.devTxd), .hostTxd(link.hostTxd),
        .devRtsN(link.devRtsN), .hostRtsN(link.hostRtsN),
        .hostToDeviceWake(link.hostToDeviceWake), .deviceToHostWake(link.deviceToHostWake)
    );

    // ------------------------------------------------------------------
    // Drivers and monitors
    // ------------------------------------------------------------------
    // Writers hold each byte until the FIFO takes it
    always @(posedge mclk) begin
        if (!hciTxValid || hciTxReady) begin
            hciTxValid <= devQ.size() > 0;
            if (devQ.size() > 0) hciTxData <= devQ.pop_front();
        end
        if (!hTxValid || hTxReady) begin
            hTxValid <= hostQ.size() > 0;
            if (hostQ.size() > 0) hTxData <= hostQ.pop_front();
        end
        if (!periTxValid || periTxReady) begin
            periTxValid <= periQ.size() > 0;
            if (periQ.size() > 0) periTxData <= periQ.pop_front();
        end
    end

    // Random readers stall; holdHost stops the host
    always @(posedge mclk) begin
        hRxReady <= !holdHost && (($random(seed) & 32'h0000_0003) != 0);
        hciRxReady <= ($random(seed) & 32'h0000_0001) != 0;
        periRxReady <= ($random(seed) & 32'h0000_0001) != 0;
        if (hRxValid === 1'b1 && hRxReady === 1'b1) checkByte(hRxData, expHost);
        if (hciRxValid === 1'b1 && hciRxReady === 1'b1) checkByte(hciRxData, expDev);
        if (periRxValid === 1'b1 && periRxReady === 1'b1) checkByte(periRxData, expPeri);
    end

    // ------------------------------------------------------------------
    // Tasks and functions
    // ------------------------------------------------------------------
    task automatic check(input logic [39:0] got, input logic [39:0] want);
        total_checks++;
        if (got !== want) begin
            failures++;
            $display("Error at %0t ns: got %h expected %h", $time, got, want);
        end
    endtask

    task automatic checkByte(input logic [7:0] got, ref logic [7:0] q[$]);
        logic [7:0] want;
        want = (q.size() > 0) ? q.pop_front() : ~got;
        check({32'h0000_0000, got}, {32'h0000_0000, want});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask

    // First device byte has bit 0 set so its start bit stands alone
    task automatic sendMix(input int n, input bit all);
        logic [7:0] b;
        for (int i = 0; i < n; i++) begin
            b = 8'($random(seed)) | ((i == 0) ? 8'h01 : 8'h00);
            devQ.push_back(b);
            expHost.push_back(b);
            if (all) begin
                b = 8'($random(seed));
                hostQ.push_back(b);
                expDev.push_back(b);
                b = 8'($random(seed));
                periQ.push_back(b);
                expPeri.push_back(b);
            end
        end
    endtask

    task automatic drain();
        for (int i = 0; i < 40000 && (expHost.size() + expDev.size() + expPeri.size()) > 0; i++)
            @(posedge mclk);
        check(40'(expHost.size() + expDev.size() + expPeri.size()), 40'h0);
    endtask

    function automatic int bitClocks(input hu_pkg::hu_baud_t r);
        int rate;
        rate = (r < `HU_BAUD_MIN) ? `HU_BAUD_MIN : ((r > `HU_BAUD_MAX) ? `HU_BAUD_MAX : r);
        return `HU_FCLK / rate;
    endfunction

    // Next device start bit length in mclk cycles
    task automatic measureStart(input hu_pkg::hu_baud_t r);
        int n;
        int want;
        n = -1;
        want = bitClocks(r);
        @(negedge link.devTxd);
        while (link.devTxd === 1'b0 && n < 1000) begin
            @(negedge mclk);
            n++;
        end
        check({39'h0, (n >= want - 1) && (n <= want + 2)}, 40'h1);
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        hu_pkg::hu_baud_t rates[3];
        rates = '{21'h1_C200, 21'h0E_1000, 21'h1F_FFFF};
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        settle(2);
        check({36'h0, link.devTxd, link.hostTxd, link.devRtsN, link.hostRtsN}, 40'hC);
        check(gpioOe, 40'h80_0000_0080);
        // Device wake outputs dark until enabled
        @(posedge mclk);
        wakeDevice <= 1'b1;
        hostWakeReq <= 1'b1;
        settle(4);
        check({37'h0, deviceAwakeReq, link.deviceToHostWake, hostWoken}, 40'h0);
        @(posedge mclk);
        wakeEnable <= 1'b1;
        hostWakeReq <= 1'b0;
        settle(4);
        check({37'h0, deviceAwakeReq, link.hostToDeviceWake, link.deviceToHostWake}, 40'h6);
        @(posedge mclk);
        hostWakeReq <= 1'b1;
        settle(4);
        check({38'h0, link.deviceToHostWake, hostWoken}, 40'h3);
        @(posedge mclk);
        hostWakeReq <= 1'b0;
        wakeDevice <= 1'b0;
        sendMix(1, 1'b0);
        settle(8);
        check({39'h0, link.deviceToHostWake}, 40'h1);
        drain();
        settle(100);
        check({39'h0, link.deviceToHostWake}, 40'h0);
        // Rates: default, intermediate, over-range (clamps)
        foreach (rates[k]) begin
            settle(100);
            baudValue <= rates[k];
            baudLoad <= 1'b1;
            @(posedge mclk);
            baudLoad <= 1'b0;
            settle(2);
            sendMix(4, 1'b1);
            measureStart(rates[k]);
            drain();
        end
        // Host stops reading: flow control halts the device, losing nothing
        @(posedge mclk);
        holdHost <= 1'b1;
        sendMix(260, 1'b0);
        for (int i = 0; i < 30000 && link.hostRtsN !== 1'b1; i++) @(negedge mclk);
        settle(1500);
        check({38'h0, link.hostRtsN, link.devTxd}, 40'h3);
        @(posedge mclk);
        holdHost <= 1'b0;
        drain();
        summarize();
    end

    // Run needs about 25k cycles; cut a hang at 60k
    initial begin
        #6_000_000;
        failures++;
        $display("Error at %0t ns: timeout, got %h expected %h", $time, 1'b0, 1'b1);
        summarize();
    end
endmodule

// ---- verif/hu_link_sva.sv ----
/*
 * Concurrent checks on the link wires between the two ends.
 * Assumes one mclk domain and rst_n asynchronous active low.
 */
`timescale 1ns/1ps

module hu_link_sva (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic devTxd,
    input wire logic hostTxd,
    input wire logic devRtsN,
    input wire logic hostRtsN,
    input wire logic hostToDeviceWake,
    input wire logic deviceToHostWake
);
    // Longest legal low run: start plus eight zeros at 115200
    localparam int LOW_MAX = 800;

    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    // Device line idle count; saturates so it never wraps
    logic [9:0] devIdle;
    logic [9:0] next_devIdle;
    assign next_devIdle = !devTxd ? 10'h000 : ((devIdle == 10'h3FF) ? devIdle : devIdle + 10'h001);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            devIdle <= 10'h000;
        end else begin
            devIdle <= next_devIdle;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // Host has refused data for a while and the line is idle
    sequence ctsHeld;
        hostRtsN[*6] ##0 (devIdle >= 10'h320);
    endsequence

    AST_RESET_LINES: assert property ($rose(rst_n) |-> devTxd && hostTxd && !devRtsN && !hostRtsN)
        else $error("link lines not idle after reset");
    AST_WAKE_RESET: assert property ($rose(rst_n) |-> !deviceToHostWake && !hostToDeviceWake)
        else $error("wake line active after reset");
    AST_DEV_BIT_MIN: assert property ($changed(devTxd) |=> $stable(devTxd)[*5])
        else $error("device bit too short");
    AST_HOST_BIT_MIN: assert property ($changed(hostTxd) |=> $stable(hostTxd)[*5])
        else $error("host bit too short");
    AST_DEV_LOW_MAX: assert property ($fell(devTxd) |-> ##[1:LOW_MAX] devTxd)
        else $error("device line low too long");
    AST_HOST_LOW_MAX: assert property ($fell(hostTxd) |-> ##[1:LOW_MAX] hostTxd)
        else $error("host line low too long");
    AST_DEV_HOLDS_FOR_CTS: assert property (ctsHeld |=> devTxd)
        else $error("device sent against flow control");
    AST_RTS_AFTER_STOP: assert property ($rose(hostRtsN) |-> $past(devTxd) && $past(devTxd, 2))
        else $error("host RTS rose outside a stop bit");
endmodule
